/* File: design/aof_consts.vh */
// aof_consts.vh: constants of the converter output formatter
// assumes: included by bare name from design and checker files
`ifndef AOF_CONSTS_VH
`define AOF_CONSTS_VH
// output modes
`define AOF_MODE_FULL      2'h0
`define AOF_MODE_DDR_SE    2'h1
`define AOF_MODE_DDR_DIFF  2'h2
// clock control field positions
`define AOF_CLK_DCS_BIT    0
`define AOF_CLK_INV_BIT    1
`define AOF_CLK_PH_LSB     2
`define AOF_CLK_PH_MSB     3
// output control field positions
`define AOF_OUT_MODE_LSB   0
`define AOF_OUT_MODE_MSB   1
`define AOF_OUT_CUR_LSB    2
`define AOF_OUT_CUR_MSB    4
`define AOF_OUT_TERM_BIT   5
// drive current code for 3.5 mA, used when strapped
`define AOF_CUR_3P5MA      3'h4
// reset values
`define AOF_CLK_CTRL_RST   4'h0
`define AOF_OUT_CTRL_RST   6'h10
// stabilizer lock time in encode cycles
`define AOF_LOCK_CYCLES    7'h64
// highest phase tap, in eighths of one encode period (four eighths per half period)
`define AOF_PH_MAX         2'h3
`define AOF_WORD_W         12
`define AOF_LANE_W         6
`endif

/* File: design/aof_formatter.v */
// aof_formatter.v: output stage of a 12-bit sampling converter
// assumes: CLK_SYS_I runs far faster than the encode clock; encode pins are sampled
`timescale 1ns/10ps
`include "aof_consts.vh"
module aof_formatter (
   input  wire        CLK_SYS_I,
   input  wire        RSTN_I,
   input  wire        ENCODE_IN_POS_I,
   input  wire        ENCODE_IN_NEG_I,
   input  wire        PROGRAM_SELECT_PIN_I,
   input  wire        CS_PIN_I,
   input  wire        SCK_PIN_I,
   input  wire [3:0]  CLOCK_CTRL_REG_I,
   input  wire [5:0]  OUTPUT_CTRL_REG_I,
   input  wire [11:0] SAMPLE_WORD_I,
   input  wire        SAMPLE_RANGE_I,
   input  wire        SAMPLE_VALID_I,
   output reg         SAMPLE_READY_O,
   output reg  [11:0] DATA_FULL_O,
   output reg  [5:0]  DDR_LANE_P_O,
   output reg  [5:0]  DDR_LANE_N_O,
   output reg         RANGE_FLAG_P_O,
   output reg         RANGE_FLAG_N_O,
   output reg         FWD_CLK_POS_O,
   output reg         FWD_CLK_NEG_O,
   output reg  [1:0]  MODE_O,
   output reg  [2:0]  DRIVE_CUR_O,
   output reg         TERM_EN_O,
   output reg         DCS_LOCKED_O
);
   // ********************************************************
   // reset release and pin synchronisers
   // ********************************************************
   reg        rst_meta_reg;
   reg        rst_sync_reg;
   wire       rstn;
   wire       enc_pos_s;
   wire       enc_neg_s;
   wire       par_s;
   wire       cs_s;
   wire       sck_s;

   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rstn = rst_sync_reg;

   aof_sync2 u_sync_encp (.clk_i(CLK_SYS_I), .rstn_i(rstn), .d_i(ENCODE_IN_POS_I),
                          .q_o(enc_pos_s));
   aof_sync2 u_sync_encn (.clk_i(CLK_SYS_I), .rstn_i(rstn), .d_i(ENCODE_IN_NEG_I),
                          .q_o(enc_neg_s));
   aof_sync2 u_sync_par  (.clk_i(CLK_SYS_I), .rstn_i(rstn), .d_i(PROGRAM_SELECT_PIN_I),
                          .q_o(par_s));
   aof_sync2 u_sync_cs   (.clk_i(CLK_SYS_I), .rstn_i(rstn), .d_i(CS_PIN_I), .q_o(cs_s));
   aof_sync2 u_sync_sck  (.clk_i(CLK_SYS_I), .rstn_i(rstn), .d_i(SCK_PIN_I), .q_o(sck_s));

   // ********************************************************
   // mode selection
   // ********************************************************
   reg        dcs_en;
   reg [1:0]  mode_sel;
   reg [2:0]  cur_sel;
   reg        term_sel;
   reg [1:0]  phase_sel;
   reg        inv_sel;

   always @* begin
      if (par_s) begin
         dcs_en    = cs_s;
         mode_sel  = sck_s ? `AOF_MODE_DDR_DIFF : `AOF_MODE_FULL;
         cur_sel   = `AOF_CUR_3P5MA;
         term_sel  = 1'b0;
         phase_sel = 2'h0;
         inv_sel   = 1'b0;
      end else begin
         dcs_en    = CLOCK_CTRL_REG_I[`AOF_CLK_DCS_BIT];
         mode_sel  = OUTPUT_CTRL_REG_I[`AOF_OUT_MODE_MSB:`AOF_OUT_MODE_LSB];
         if (mode_sel == 2'h3) begin
            mode_sel = `AOF_MODE_FULL;
         end
         cur_sel   = OUTPUT_CTRL_REG_I[`AOF_OUT_CUR_MSB:`AOF_OUT_CUR_LSB];
         term_sel  = OUTPUT_CTRL_REG_I[`AOF_OUT_TERM_BIT];
         phase_sel = CLOCK_CTRL_REG_I[`AOF_CLK_PH_MSB:`AOF_CLK_PH_LSB];
         inv_sel   = CLOCK_CTRL_REG_I[`AOF_CLK_INV_BIT];
      end
   end

   // ********************************************************
   // encode edge detection and period measure
   // ********************************************************
   reg        enc_prev_reg;
   reg [15:0] per_cnt_reg;
   reg [15:0] per_len_reg;
   reg [6:0]  lock_cnt_reg;
   reg        dcs_en_prev_reg;
   wire       enc_lvl;
   wire       enc_rise;
   wire       enc_fall;

   // single-ended drive when the complement sits low, else differential
   assign enc_lvl  = enc_pos_s & ~enc_neg_s;
   assign enc_rise = enc_lvl & ~enc_prev_reg;
   assign enc_fall = ~enc_lvl & enc_prev_reg;

   always @(posedge CLK_SYS_I or negedge rstn) begin
      if (!rstn) begin
         enc_prev_reg    <= 1'b0;
         per_cnt_reg     <= 16'h0000;
         per_len_reg     <= 16'h0000;
         lock_cnt_reg    <= 7'h00;
         dcs_en_prev_reg <= 1'b0;
      end else begin
         enc_prev_reg    <= enc_lvl;
         dcs_en_prev_reg <= dcs_en;
         if (enc_rise) begin
            per_cnt_reg <= 16'h0001;
            per_len_reg <= per_cnt_reg;
            // a period change or restart drops the lock
            if (!dcs_en || (per_cnt_reg != per_len_reg)) begin
               lock_cnt_reg <= 7'h00;
            end else if (lock_cnt_reg != `AOF_LOCK_CYCLES) begin
               lock_cnt_reg <= lock_cnt_reg + 7'h01;
            end
         end else begin
            if (per_cnt_reg != 16'hFFFF) begin
               per_cnt_reg <= per_cnt_reg + 16'h0001;
            end else begin
               lock_cnt_reg <= 7'h00;
            end
         end
         if (dcs_en != dcs_en_prev_reg) begin
            lock_cnt_reg <= 7'h00;
         end
      end
   end

   // ********************************************************
   // internal clock: stabilized 50 percent or raw encode
   // ********************************************************
   reg        int_clk_reg;
   reg        int_rise_reg;
   reg        int_fall_reg;
   reg [15:0] ph_cnt_reg;
   wire       locked;
   wire [15:0] half_len;
   wire [15:0] eighth_len;
   wire [15:0] delay_len;

   assign locked     = (lock_cnt_reg == `AOF_LOCK_CYCLES);
   assign half_len   = {1'b0, per_len_reg[15:1]};
   assign eighth_len = {3'h0, per_len_reg[15:3]};
   assign delay_len  = (locked && dcs_en) ?
                       (({16{phase_sel[0]}} & eighth_len) +
                        ({16{phase_sel[1]}} & {eighth_len[14:0], 1'b0})) :
                       16'h0000;

   always @(posedge CLK_SYS_I or negedge rstn) begin
      if (!rstn) begin
         int_clk_reg  <= 1'b0;
         int_rise_reg <= 1'b0;
         int_fall_reg <= 1'b0;
         ph_cnt_reg   <= 16'h0000;
      end else begin
         int_rise_reg <= 1'b0;
         int_fall_reg <= 1'b0;
         if (enc_rise) begin
            ph_cnt_reg   <= 16'h0001;
            int_clk_reg  <= 1'b1;
            int_rise_reg <= 1'b1;
         end else begin
            if (ph_cnt_reg != 16'hFFFF) begin
               ph_cnt_reg <= ph_cnt_reg + 16'h0001;
            end
            // stabilizer puts the fall mid-period whatever the duty
            if (dcs_en && locked) begin
               if (int_clk_reg && ph_cnt_reg == half_len) begin
                  int_clk_reg  <= 1'b0;
                  int_fall_reg <= 1'b1;
               end
            end else if (int_clk_reg && enc_fall) begin
               int_clk_reg  <= 1'b0;
               int_fall_reg <= 1'b1;
            end
         end
      end
   end

   // ********************************************************
   // two-entry sample buffer
   // ********************************************************
   reg [12:0] buf_mem_reg [0:1];
   reg        wr_ptr_reg;
   reg        rd_ptr_reg;
   reg [1:0]  cnt_reg;
   wire       buf_empty;
   wire       take_word;
   wire       push;

   assign buf_empty = (cnt_reg == 2'h0);
   assign push      = SAMPLE_VALID_I & SAMPLE_READY_O;
   assign take_word = int_rise_reg & ~buf_empty;

   always @(posedge CLK_SYS_I or negedge rstn) begin
      if (!rstn) begin
         buf_mem_reg[0] <= 13'h0000;
         buf_mem_reg[1] <= 13'h0000;
         wr_ptr_reg     <= 1'b0;
         rd_ptr_reg     <= 1'b0;
         cnt_reg        <= 2'h0;
         SAMPLE_READY_O <= 1'b0;
      end else begin
         if (push) begin
            buf_mem_reg[wr_ptr_reg] <= {SAMPLE_RANGE_I, SAMPLE_WORD_I};
            wr_ptr_reg              <= ~wr_ptr_reg;
         end
         if (take_word) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         cnt_reg        <= cnt_reg + {1'b0, push} - {1'b0, take_word};
         SAMPLE_READY_O <= ((cnt_reg + {1'b0, push} - {1'b0, take_word}) < 2'h2) &&
                           !(push && cnt_reg == 2'h1 && !take_word);
      end
   end

   // ********************************************************
   // output word, lanes and forwarded clock
   // ********************************************************
   reg [12:0] word_reg;
   reg [15:0] dly_cnt_reg;
   reg        dly_run_reg;
   reg        dly_lvl_reg;
   reg        fwd_base_reg;
   reg [5:0]  lane_reg;
   wire [5:0] even_bits;
   wire [5:0] odd_bits;
   wire       fwd_lvl;
   integer    k;
   reg [5:0]  ev;
   reg [5:0]  od;

   always @* begin
      ev = 6'h00;
      od = 6'h00;
      for (k = 0; k < `AOF_LANE_W; k = k + 1) begin
         ev[k] = word_reg[2 * k];
         od[k] = word_reg[2 * k + 1];
      end
   end
   assign even_bits = ev;
   assign odd_bits  = od;
   assign fwd_lvl   = fwd_base_reg ^ inv_sel;

   always @(posedge CLK_SYS_I or negedge rstn) begin
      if (!rstn) begin
         word_reg     <= 13'h0000;
         dly_cnt_reg  <= 16'h0000;
         dly_run_reg  <= 1'b0;
         dly_lvl_reg  <= 1'b0;
         fwd_base_reg <= 1'b0;
         lane_reg     <= 6'h00;
      end else begin
         if (int_rise_reg) begin
            word_reg <= buf_empty ? word_reg : buf_mem_reg[rd_ptr_reg];
         end
         // lanes follow the undelayed phase, level with the clock stage
         lane_reg <= dly_lvl_reg ? odd_bits : even_bits;
         // a due clock step lands even when the next phase starts then
         if (dly_run_reg && dly_cnt_reg == 16'h0000) begin
            fwd_base_reg <= dly_lvl_reg;
         end
         // forwarded clock follows internal clock after the phase delay
         if (int_rise_reg || int_fall_reg) begin
            dly_lvl_reg <= int_rise_reg;
            dly_cnt_reg <= delay_len;
            dly_run_reg <= 1'b1;
         end else if (dly_run_reg) begin
            if (dly_cnt_reg == 16'h0000) begin
               dly_run_reg  <= 1'b0;
            end else begin
               dly_cnt_reg <= dly_cnt_reg - 16'h0001;
            end
         end
      end
   end

   always @(posedge CLK_SYS_I or negedge rstn) begin
      if (!rstn) begin
         DATA_FULL_O    <= 12'h000;
         DDR_LANE_P_O   <= 6'h00;
         DDR_LANE_N_O   <= 6'h3F;
         RANGE_FLAG_P_O <= 1'b0;
         RANGE_FLAG_N_O <= 1'b1;
         FWD_CLK_POS_O  <= 1'b0;
         FWD_CLK_NEG_O  <= 1'b1;
         MODE_O         <= `AOF_MODE_FULL;
         DRIVE_CUR_O    <= `AOF_CUR_3P5MA;
         TERM_EN_O      <= 1'b0;
         DCS_LOCKED_O   <= 1'b0;
      end else begin
         MODE_O         <= mode_sel;
         DRIVE_CUR_O    <= cur_sel;
         TERM_EN_O      <= term_sel && (mode_sel == `AOF_MODE_DDR_DIFF);
         DCS_LOCKED_O   <= locked && dcs_en;
         FWD_CLK_POS_O  <= fwd_lvl;
         FWD_CLK_NEG_O  <= ~fwd_lvl;
         RANGE_FLAG_P_O <= word_reg[12];
         RANGE_FLAG_N_O <= (mode_sel == `AOF_MODE_DDR_DIFF) ? ~word_reg[12] : 1'b0;
         case (mode_sel)
            `AOF_MODE_FULL: begin
               DATA_FULL_O  <= word_reg[11:0];
               DDR_LANE_P_O <= 6'h00;
               DDR_LANE_N_O <= 6'h00;
            end
            `AOF_MODE_DDR_SE: begin
               DATA_FULL_O  <= 12'h000;
               DDR_LANE_P_O <= lane_reg;
               DDR_LANE_N_O <= 6'h00;
            end
            `AOF_MODE_DDR_DIFF: begin
               DATA_FULL_O  <= 12'h000;
               DDR_LANE_P_O <= lane_reg;
               DDR_LANE_N_O <= ~lane_reg;
            end
            default: begin
               DATA_FULL_O  <= 12'h000;
               DDR_LANE_P_O <= 6'h00;
               DDR_LANE_N_O <= 6'h00;
            end
         endcase
      end
   end
endmodule

/* File: design/aof_sync2.v */
// aof_sync2.v: two flip-flop synchroniser for one level
// assumes: input comes from another clock domain or a pin
`timescale 1ns/10ps
module aof_sync2 (
   input  wire clk_i,
   input  wire rstn_i,
   input  wire d_i,
   output wire q_o
);
   reg meta_reg;
   reg sync_reg;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end
   assign q_o = sync_reg;
endmodule

/* File: tb/aof_formatter_asserts.sv */
// aof_formatter_asserts.sv: port checker for the converter output formatter
// assumes: bound to aof_formatter; encode clock far slower than the system clock
`timescale 1ns/10ps
`include "aof_consts.vh"
// ************************************************************
// checker
// ************************************************************
module aof_asserts (
   input wire        CLK_SYS_I,
   input wire        RSTN_I,
   input wire        ENCODE_IN_POS_I,
   input wire        PROGRAM_SELECT_PIN_I,
   input wire        CS_PIN_I,
   input wire        SCK_PIN_I,
   input wire [3:0]  CLOCK_CTRL_REG_I,
   input wire [5:0]  OUTPUT_CTRL_REG_I,
   input wire [11:0] DATA_FULL_O,
   input wire [5:0]  DDR_LANE_P_O,
   input wire [5:0]  DDR_LANE_N_O,
   input wire        RANGE_FLAG_P_O,
   input wire        RANGE_FLAG_N_O,
   input wire        FWD_CLK_POS_O,
   input wire        FWD_CLK_NEG_O,
   input wire [1:0]  MODE_O,
   input wire [2:0]  DRIVE_CUR_O,
   input wire        TERM_EN_O,
   input wire        DCS_LOCKED_O
);
   reg       enc_d_reg;
   reg [7:0] rise_cnt_reg;
   wire      dcs_en = PROGRAM_SELECT_PIN_I ? CS_PIN_I : CLOCK_CTRL_REG_I[0];
   wire [1:0] reg_mode = (OUTPUT_CTRL_REG_I[1:0] == 2'h3) ? 2'h0 : OUTPUT_CTRL_REG_I[1:0];
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   // encode rises seen while stabilizer on and not locked
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         enc_d_reg <= 1'b0;
         rise_cnt_reg <= 8'h00;
      end else begin
         enc_d_reg <= ENCODE_IN_POS_I;
         if (!dcs_en || DCS_LOCKED_O) begin
            rise_cnt_reg <= 8'h00;
         end else if (ENCODE_IN_POS_I && !enc_d_reg && rise_cnt_reg != 8'hFF) begin
            rise_cnt_reg <= rise_cnt_reg + 8'h01;
         end
      end
   end
   a_clk_neg_inv: assert property (FWD_CLK_NEG_O == !FWD_CLK_POS_O)
      else $error("negative clock not inverse");
   a_lane_pair: assert property (
      MODE_O == `AOF_MODE_DDR_DIFF |-> DDR_LANE_N_O == ~DDR_LANE_P_O)
      else $error("lane pair not inverse");
   a_flag_pair: assert property (
      MODE_O == `AOF_MODE_DDR_DIFF |-> RANGE_FLAG_N_O != RANGE_FLAG_P_O)
      else $error("flag pair not inverse");
   a_unused_low: assert property (
      (MODE_O == `AOF_MODE_DDR_SE)[*3] |->
      DATA_FULL_O == 12'h000 && DDR_LANE_N_O == 6'h00 && !RANGE_FLAG_N_O)
      else $error("unused lines not low");
   a_reg_mode: assert property (
      (!PROGRAM_SELECT_PIN_I && $stable(OUTPUT_CTRL_REG_I))[*8] |-> MODE_O == reg_mode)
      else $error("mode differs from register");
   a_reg_drive: assert property (
      (!PROGRAM_SELECT_PIN_I && $stable(OUTPUT_CTRL_REG_I))[*8] ##0
      MODE_O == `AOF_MODE_DDR_DIFF |->
      DRIVE_CUR_O == OUTPUT_CTRL_REG_I[4:2] && TERM_EN_O == OUTPUT_CTRL_REG_I[5])
      else $error("drive or termination wrong");
   a_strap_diff: assert property (
      (PROGRAM_SELECT_PIN_I && SCK_PIN_I)[*8] |->
      MODE_O == `AOF_MODE_DDR_DIFF && DRIVE_CUR_O == `AOF_CUR_3P5MA)
      else $error("strap ddr mode wrong");
   a_strap_dcs: assert property ((PROGRAM_SELECT_PIN_I && !CS_PIN_I)[*8] |-> !DCS_LOCKED_O)
      else $error("stabilizer on with select low");
   a_lock_time: assert property ($rose(DCS_LOCKED_O) |-> rise_cnt_reg >= `AOF_LOCK_CYCLES)
      else $error("locked too early");
   a_ddr_edges: assert property (
      $stable(MODE_O) && MODE_O != `AOF_MODE_FULL && CLOCK_CTRL_REG_I[3:2] == 2'h0 &&
      $changed(DDR_LANE_P_O) |-> $changed(FWD_CLK_POS_O))
      else $error("lane change off clock edge");
endmodule
bind aof_formatter aof_asserts u_chk (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I),
   .ENCODE_IN_POS_I(ENCODE_IN_POS_I), .PROGRAM_SELECT_PIN_I(PROGRAM_SELECT_PIN_I),
   .CS_PIN_I(CS_PIN_I), .SCK_PIN_I(SCK_PIN_I), .CLOCK_CTRL_REG_I(CLOCK_CTRL_REG_I),
   .OUTPUT_CTRL_REG_I(OUTPUT_CTRL_REG_I), .DATA_FULL_O(DATA_FULL_O),
   .DDR_LANE_P_O(DDR_LANE_P_O), .DDR_LANE_N_O(DDR_LANE_N_O), .RANGE_FLAG_P_O(RANGE_FLAG_P_O),
   .RANGE_FLAG_N_O(RANGE_FLAG_N_O), .FWD_CLK_POS_O(FWD_CLK_POS_O),
   .FWD_CLK_NEG_O(FWD_CLK_NEG_O), .MODE_O(MODE_O), .DRIVE_CUR_O(DRIVE_CUR_O),
   .TERM_EN_O(TERM_EN_O), .DCS_LOCKED_O(DCS_LOCKED_O));

/* File: tb/aof_rx_model.sv */
// aof_rx_model.sv: receiver that rebuilds words from the formatter outputs
// assumes: sampled on the system clock, undelayed forwarded clock
`timescale 1ns/10ps
// ************************************************************
// receiver
// ************************************************************
module aof_rx_model (
   input  wire        clk_i,
   input  wire        rstn_i,
   input  wire [1:0]  mode_i,
   input  wire [11:0] data_i,
   input  wire [5:0]  lane_i,
   input  wire        flag_i,
   input  wire        fwd_i,
   input  wire        locked_i,
   input  wire        dcs_on_i,
   output reg  [11:0] word_o,
   output reg         flag_o,
   output wire        trust_o
);
   reg [5:0]  lane_d;
   reg [5:0]  odd_reg;
   reg [11:0] data_d;
   reg        flag_d;
   reg        fwd_d;
   integer    k;
   // words during lock time are not trusted
   assign trust_o = !dcs_on_i || locked_i;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lane_d <= 6'h00;
         odd_reg <= 6'h00;
         data_d <= 12'h000;
         flag_d <= 1'b0;
         fwd_d <= 1'b0;
         word_o <= 12'h000;
         flag_o <= 1'b0;
      end else begin
         lane_d <= lane_i;
         data_d <= data_i;
         flag_d <= flag_i;
         fwd_d <= fwd_i;
         if (!fwd_i && fwd_d) begin
            odd_reg <= lane_d;
         end
         if (fwd_i && !fwd_d) begin
            flag_o <= flag_d;
            if (mode_i == 2'h0) begin
               word_o <= data_d;
            end else begin
               for (k = 0; k < 6; k = k + 1) begin
                  word_o[2*k] <= lane_d[k];
                  word_o[2*k+1] <= odd_reg[k];
               end
            end
         end
      end
   end
endmodule

/* File: tb/tb.sv */
// tb.sv: self-checking bench of the converter output formatter
// assumes: encode pin made here at 320 ns, single-ended with negative pin low
`timescale 1ns/10ps
// ************************************************************
// bench
// ************************************************************
module tb;
   logic clk = 0, rstn = 0, enc = 0, psel = 0, cs = 0, sck = 0, valid = 0, rng = 0;
   logic [3:0] cc = 4'h0;
   logic [5:0] oc = 6'h00;
   logic [11:0] wd = 12'h000;
   real enc_hi = 160.0, enc_cur = 160.0; // half duty unless stabilizer on
   bit enc_run = 1;
   int err_count = 0, tests_run = 0;
   wire ready, fcp, fcn, fp, fn, term, lock, rx_flag, rx_trust;
   wire [11:0] dfull, rx_word;
   wire [5:0] lp, ln;
   wire [1:0] mode;
   wire [2:0] cur;
   aof_formatter dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .ENCODE_IN_POS_I(enc),
      .ENCODE_IN_NEG_I(1'b0), .PROGRAM_SELECT_PIN_I(psel), .CS_PIN_I(cs), .SCK_PIN_I(sck),
      .CLOCK_CTRL_REG_I(cc), .OUTPUT_CTRL_REG_I(oc), .SAMPLE_WORD_I(wd), .SAMPLE_RANGE_I(rng),
      .SAMPLE_VALID_I(valid), .SAMPLE_READY_O(ready), .DATA_FULL_O(dfull), .DDR_LANE_P_O(lp),
      .DDR_LANE_N_O(ln), .RANGE_FLAG_P_O(fp), .RANGE_FLAG_N_O(fn), .FWD_CLK_POS_O(fcp),
      .FWD_CLK_NEG_O(fcn), .MODE_O(mode), .DRIVE_CUR_O(cur), .TERM_EN_O(term),
      .DCS_LOCKED_O(lock));
   aof_rx_model rx (.clk_i(clk), .rstn_i(rstn), .mode_i(mode), .data_i(dfull), .lane_i(lp),
      .flag_i(fp), .fwd_i(fcp), .locked_i(lock), .dcs_on_i(cc[0]), .word_o(rx_word),
      .flag_o(rx_flag), .trust_o(rx_trust));
   initial begin
      forever #20 clk = ~clk;
   end
   initial begin
      #7.3;
      forever begin
         enc_cur = enc_hi;
         if (enc_run) begin
            enc = 1'b1;
            #(enc_cur);
            enc = 1'b0;
            #(320.0 - enc_cur);
         end else #320;
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic push(input logic [11:0] w, input logic r, output bit ok);
      int n = 0;
      wd = w;
      rng = r;
      valid = 1'b1;
      while (ready !== 1'b1 && n < 4) begin
         cyc(1);
         n++;
      end
      ok = (ready === 1'b1);
      cyc(1);
      valid = 1'b0;
   endtask
   task automatic t_modes;
      bit ok;
      logic [1:0] em;
      for (int m = 0; m < 4; m++) begin
         oc = {1'b1, 3'h2, m[1:0]};
         push(12'h9C6 + m, m[0], ok);
         cyc(48);
         em = (m == 3) ? 2'h0 : m[1:0];
         chk(ok, "push refused");
         chk(mode === em, "mode");
         chk(rx_word === 12'h9C6 + m && rx_flag === m[0], "word");
         chk(fcn === ~fcp, "neg clock");
         if (em == 1) chk(ln === 6'h00 && dfull === 12'h000, "unused");
         if (em == 2) chk(ln === ~lp && cur === 3'h2 && term === 1'b1, "diff");
         if (em == 0) chk(term === 1'b0, "term");
      end
   endtask
   task automatic wait_word(input logic [11:0] w);
      int n = 0;
      while (rx_word !== w && n < 200) begin
         cyc(1);
         n++;
      end
      chk(rx_word === w, "order");
   endtask
   task automatic t_buffer;
      bit ok;
      int acc = 0;
      oc = 6'h10;
      enc_run = 0;
      cyc(24);
      for (int i = 0; i < 3; i++) begin
         push(12'h123 * (i + 1), 1'b0, ok);
         acc += ok;
         cyc(1);
      end
      chk(acc == 2, "buffer depth");
      enc_run = 1;
      wait_word(12'h123);
      wait_word(12'h246);
   endtask
   task automatic hi_len(output int h);
      int n = 0;
      h = 0;
      while (fcp !== 1'b0 && n < 20) begin
         cyc(1);
         n++;
      end
      while (fcp !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      while (fcp === 1'b1 && h < 20) begin
         cyc(1);
         h++;
      end
   endtask
   task automatic t_lock;
      int h;
      cc = 4'h1;
      enc_hi = 96.0;
      cyc(400);
      chk(lock === 1'b0 && rx_trust === 1'b0, "early lock");
      cyc(560);
      chk(lock === 1'b1, "no lock");
      for (int i = 0; i < 2; i++) begin
         enc_hi = i ? 224.0 : 96.0;
         cyc(16);
         hi_len(h);
         chk(h == 4, "duty");
      end
   endtask
   task automatic t_phase;
      bit ok;
      int d, n;
      logic [5:0] l0;
      logic f0;
      logic [3:0] cfg [6] = '{4'h1, 4'h5, 4'h9, 4'hD, 4'h7, 4'h8};
      int exd [6] = '{0, 1, 2, 3, 1, 0};
      enc_hi = 160.0;
      oc = 6'h11;
      push(12'h555, 1'b0, ok);
      for (int i = 0; i < 6; i++) begin
         cc = cfg[i];
         cyc(32);
         l0 = lp;
         f0 = fcp;
         n = 0;
         cyc(1);
         while (lp === l0 && n < 20) begin
            f0 = fcp;
            cyc(1);
            n++;
         end
         d = 0;
         while (fcp === f0 && d < 8) begin
            cyc(1);
            d++;
         end
         chk(d == exd[i], "clock delay");
         chk((lp === 6'h00) == (fcp ^ cfg[i][1]), "clock polarity");
      end
   endtask
   task automatic t_strap;
      cc = 4'h0;
      oc = 6'h01;
      psel = 1;
      sck = 1;
      cs = 0;
      cyc(12);
      chk(mode === 2'h2 && cur === 3'h4 && term === 1'b0, "strap ddr");
      sck = 0;
      cyc(12);
      chk(mode === 2'h0 && lock === 1'b0, "strap full");
      cs = 1;
      cyc(960);
      chk(lock === 1'b1, "strap lock");
   endtask
   task automatic results;
      $display("err_count=%0d tests_run=%0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      results;
   end
   initial begin
      cyc(2);
      rstn = 1;
      cyc(8);
      t_modes;
      t_buffer;
      t_lock;
      t_phase;
      t_strap;
      results;
   end
endmodule
